// File: duart_ctl.sv
`timescale 1ns/1ps
module duart_ctl
  import duart_ctl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [1:0] i_serial_in_pin,
  output logic [1:0] o_serial_out_pin,
  input wire logic [2:0] i_general_input_pins,
  output logic o_irq,
  output logic o_mode_ptr_first
);

  // =====================================================
  // bus slave
  logic aw_q, w_q;
  logic [7:0] awa_q;
  logic [7:0] wd_q;
  logic wst_q;
  logic wr_go, rd_go;
  assign wr_go = aw_q && w_q && !o_bvalid;
  assign rd_go = i_arvalid && o_arready;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 8'h00;
      wst_q <= 1'b0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_q <= 1'b1;
        awa_q <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_q <= 1'b1;
        wd_q <= i_wdata[7:0];
        wst_q <= i_wstrb[0];
        o_wready <= 1'b0;
      end
      if (wr_go) begin
        o_bvalid <= 1'b1;
        aw_q <= 1'b0;
        w_q <= 1'b0;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end
  assign o_bresp = 2'b00;
  assign o_rresp = 2'b00;

  logic [7:0] wdat;
  logic [1:0] wr_cmd, wr_txb;
  assign wdat = wst_q ? wd_q : 8'h00;
  assign wr_cmd[0] = wr_go && wst_q && awa_q == cmd_a_off;
  assign wr_cmd[1] = wr_go && wst_q && awa_q == cmd_b_off;
  assign wr_txb[0] = wr_go && wst_q && awa_q == txb_a_off;
  assign wr_txb[1] = wr_go && wst_q && awa_q == txb_b_off;
  logic wr_acr, wr_imr, wr_ctl, rd_ipcr;
  logic [1:0] rd_rxb;
  assign wr_acr = wr_go && wst_q && awa_q == acr_off;
  assign wr_imr = wr_go && wst_q && awa_q == imr_off;
  assign wr_ctl = wr_go && wst_q && awa_q == ctl_off;
  assign rd_ipcr = rd_go && i_araddr == ipcr_off;
  assign rd_rxb[0] = rd_go && i_araddr == rxb_a_off;
  assign rd_rxb[1] = rd_go && i_araddr == rxb_b_off;

  // =====================================================
  // global registers
  logic [7:0] acr_q, imr_q, ctl_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acr_q <= acr_reset;
      imr_q <= 8'h00;
      ctl_q <= 8'h00;
    end else begin
      if (wr_acr) acr_q <= wdat;
      if (wr_imr) imr_q <= wdat;
      if (wr_ctl) ctl_q <= wdat;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) o_mode_ptr_first <= 1'b0;
    else if (wr_cmd != 2'b00) o_mode_ptr_first <= wdat[op_lsb +: 3] == op_mptr;
  end

  // shared 16x sample tick
  logic [11:0] div_q;
  logic tick;
  assign tick = div_q == 12'(sample_div - 1);
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) div_q <= 12'h000;
    else div_q <= tick ? 12'h000 : div_q + 12'h001;
  end

  // =====================================================
  // channels
  logic [7:0] sts [2];
  logic [7:0] rxtop [2];
  logic [1:0] full, rdy, tx_holding_free, dbrk_set;
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      chan_op_type op;
      logic [1:0] tcmd, rcmd;
      logic cmd;
      assign cmd = wr_cmd[c];
      assign op = chan_op_type'(wdat[op_lsb +: 3]);
      assign tcmd = wdat[tx_cmd_lsb +: 2];
      assign rcmd = wdat[rx_cmd_lsb +: 2];
      // ---- transmitter ----
      tx_state_type txs_q;
      logic txen_q, hfree_q, idle_q, brkreq_q, so_q;
      logic [7:0] hold_q, sh_q;
      logic [3:0] tph_q, tbit_q;
      logic bit_end;
      assign bit_end = tick && tph_q == 4'hf;
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          txs_q <= tx_idle;
          txen_q <= 1'b0;
          hfree_q <= 1'b0;
          idle_q <= 1'b0;
          brkreq_q <= 1'b0;
          so_q <= 1'b1;
          hold_q <= 8'h00;
          sh_q <= 8'h00;
          tph_q <= 4'h0;
          tbit_q <= 4'h0;
        end else begin
          if (tick) tph_q <= tph_q + 4'h1;
          case (txs_q)
            tx_idle: begin
              so_q <= 1'b1;
              if (brkreq_q && bit_end) begin
                txs_q <= tx_brk;
                so_q <= 1'b0;
              end else if (txen_q && !hfree_q && bit_end) begin
                sh_q <= hold_q;
                hfree_q <= 1'b1;
                idle_q <= 1'b0;
                so_q <= 1'b0;
                tbit_q <= 4'h0;
                txs_q <= tx_shift;
              end
            end
            tx_shift: if (bit_end) begin
              tbit_q <= tbit_q + 4'h1;
              if (tbit_q < 4'h8) begin
                so_q <= sh_q[0];
                sh_q <= {1'b0, sh_q[7:1]};
              end else if (tbit_q == 4'h8) so_q <= 1'b1;
              else begin
                txs_q <= tx_idle;
                if (txen_q && hfree_q) idle_q <= 1'b1;
              end
            end
            tx_brk: begin
              so_q <= 1'b0;
              if (!brkreq_q && bit_end) begin
                so_q <= 1'b1;
                txs_q <= tx_idle;
              end
            end
            default: txs_q <= tx_idle;
          endcase
          if (wr_txb[c] && txen_q && hfree_q) begin
            hold_q <= wdat;
            hfree_q <= 1'b0;
            idle_q <= 1'b0;
          end
          if (cmd) begin
            if (op == op_brk_on && txen_q) brkreq_q <= 1'b1;
            if (op == op_brk_off) brkreq_q <= 1'b0;
            if (tcmd == cmd_dis) begin
              txen_q <= 1'b0;
              hfree_q <= 1'b0;
              idle_q <= 1'b0;
            end
            if (tcmd == cmd_en && !txen_q) begin
              txen_q <= 1'b1;
              hfree_q <= 1'b1;
              idle_q <= 1'b1;
            end
            if (op == op_rst_tx) begin
              txen_q <= 1'b0;
              hfree_q <= 1'b0;
              idle_q <= 1'b0;
              brkreq_q <= 1'b0;
              txs_q <= tx_idle;
              so_q <= 1'b1;
            end
          end
        end
      end
      assign o_serial_out_pin[c] = so_q;
      assign tx_holding_free[c] = hfree_q;

      // ---- receiver ----
      logic [1:0] sy_q;
      logic rxd;
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) sy_q <= 2'b11;
        else sy_q <= {sy_q[0], i_serial_in_pin[c]};
      end
      assign rxd = ctl_q[ctl_loop] ? so_q : sy_q[1];
      rx_state_type rxs_q;
      logic rxen_q, shv_q, brk_q, fe_q, pe_q, oe_q, rb_q;
      logic [7:0] rsh_q, sdat_q;
      logic [1:0] serr_q;
      logic [3:0] rph_q, rbit_q;
      logic [7:0] q_d [rxq_depth];
      logic [1:0] q_e [rxq_depth];
      logic [1:0] cnt_q;
      logic run;
      assign run = rxen_q || ctl_q[ctl_loop] || ctl_q[ctl_mdrop];
      logic pop, push;
      assign pop = rd_rxb[c] && cnt_q != 2'd0;
      assign push = shv_q && (cnt_q != 2'(rxq_depth) || pop);
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          rxs_q <= rx_off;
          rxen_q <= 1'b0;
          shv_q <= 1'b0;
          brk_q <= 1'b0;
          fe_q <= 1'b0;
          pe_q <= 1'b0;
          oe_q <= 1'b0;
          rb_q <= 1'b0;
          rsh_q <= 8'h00;
          sdat_q <= 8'h00;
          serr_q <= 2'b00;
          rph_q <= 4'h0;
          rbit_q <= 4'h0;
          cnt_q <= 2'd0;
          dbrk_set[c] <= 1'b0;
          for (int i = 0; i < rxq_depth; i++) begin
            q_d[i] <= 8'h00;
            q_e[i] <= 2'b00;
          end
        end else begin
          dbrk_set[c] <= 1'b0;
          if (tick) rph_q <= rph_q + 4'h1;
          if (pop) begin
            for (int i = 0; i < rxq_depth - 1; i++) begin
              q_d[i] <= q_d[i + 1];
              q_e[i] <= q_e[i + 1];
            end
          end
          if (push) begin
            q_d[pop ? cnt_q - 2'd1 : cnt_q] <= sdat_q;
            q_e[pop ? cnt_q - 2'd1 : cnt_q] <= serr_q;
            shv_q <= 1'b0;
          end
          cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
          case (rxs_q)
            rx_off: if (run) rxs_q <= rx_hunt;
            rx_hunt: if (!run) rxs_q <= rx_off;
              else if (tick && !rxd) begin
                rph_q <= 4'h9;
                rbit_q <= 4'h0;
                rxs_q <= rx_data;
              end
            rx_data: if (!run) rxs_q <= rx_off;
              else if (tick && rph_q == 4'h7) begin
                rbit_q <= rbit_q + 4'h1;
                if (rbit_q == 4'h0 && rxd) rxs_q <= rx_hunt;
                else if (rbit_q < 4'h9 && rbit_q != 4'h0) rsh_q <= {rxd, rsh_q[7:1]};
                else if (rbit_q == 4'h9) begin
                  rxs_q <= rx_hunt;
                  if (rsh_q == 8'h00 && !rxd) begin
                    if (!brk_q) begin
                      brk_q <= 1'b1;
                      dbrk_set[c] <= 1'b1;
                    end
                  end
                  if (!brk_q) begin
                    if (shv_q && !push) oe_q <= 1'b1;
                    shv_q <= 1'b1;
                    sdat_q <= rsh_q;
                    serr_q <= {rsh_q == 8'h00 && !rxd, !rxd};
                  end
                end
              end
            default: rxs_q <= rx_off;
          endcase
          if (brk_q && rxs_q == rx_hunt && tick && rxd) begin
            brk_q <= 1'b0;
            dbrk_set[c] <= 1'b1;
          end
          if (cmd) begin
            if (rcmd == cmd_en && !rxen_q) begin
              rxen_q <= 1'b1;
              if (!ctl_q[ctl_mdrop]) rxs_q <= rx_hunt;
            end
            if (rcmd == cmd_dis) rxen_q <= 1'b0;
            if (op == op_rst_rx) begin
              rxen_q <= 1'b0;
              cnt_q <= 2'd0;
              shv_q <= 1'b0;
              rxs_q <= rx_off;
            end
            if (op == op_rst_err) begin
              oe_q <= 1'b0;
              for (int i = 0; i < rxq_depth; i++) q_e[i] <= 2'b00;
            end
          end
        end
      end
      assign full[c] = cnt_q == 2'(rxq_depth);
      assign rdy[c] = cnt_q != 2'd0;
      assign rxtop[c] = q_d[0];
      assign sts[c] = {q_e[0][1] & rdy[c], q_e[0][0] & rdy[c], 1'b0, oe_q,
                       idle_q, hfree_q, full[c], rdy[c]};
    end
  endgenerate

  // =====================================================
  // input pin change detection
  logic [2:0] ips1_q, ips2_q, ipst_q, cos_q;
  logic [2:0] cos_set;
  logic isr_cos_q;
  logic [1:0] db_q;
  generate
    for (c = 0; c < 3; c++) begin : g_ip
      logic [9:0] fc_q;
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          ips1_q[c] <= 1'b1;
          ips2_q[c] <= 1'b1;
          ipst_q[c] <= 1'b1;
          fc_q <= 10'h000;
        end else begin
          ips1_q[c] <= i_general_input_pins[c];
          ips2_q[c] <= ips1_q[c];
          if (ips2_q[c] == ipst_q[c]) fc_q <= 10'h000;
          else if (fc_q == 10'(cos_filter_cyc - 1)) begin
            ipst_q[c] <= ips2_q[c];
            fc_q <= 10'h000;
          end else fc_q <= fc_q + 10'h001;
        end
      end
      assign cos_set[c] = ips2_q[c] != ipst_q[c] && fc_q == 10'(cos_filter_cyc - 1);
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cos_q <= 3'b000;
      isr_cos_q <= 1'b0;
      db_q <= 2'b00;
    end else begin
      cos_q <= (rd_ipcr ? 3'b000 : cos_q) | cos_set;
      if ((cos_set & acr_q[2:0]) != 3'b000) isr_cos_q <= 1'b1;
      else if (rd_ipcr) isr_cos_q <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        if (dbrk_set[i]) db_q[i] <= 1'b1;
        else if (wr_cmd[i] && wdat[op_lsb +: 3] == op_rst_brk) db_q[i] <= 1'b0;
      end
    end
  end

  logic [7:0] isr;
  assign isr = {isr_cos_q, db_q[1], full[1], tx_holding_free[1], 1'b0, db_q[0], full[0], tx_holding_free[0]};

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) o_irq <= 1'b0;
    else o_irq <= (isr & imr_q) != 8'h00;
  end

  // =====================================================
  // read data
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
    end else if (rd_go) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      if (i_araddr == rxb_a_off) o_rdata <= {24'h0, rxtop[0]};
      else if (i_araddr == rxb_b_off) o_rdata <= {24'h0, rxtop[1]};
      else if (i_araddr == sts_a_off) o_rdata <= {24'h0, sts[0]};
      else if (i_araddr == sts_b_off) o_rdata <= {24'h0, sts[1]};
      else if (i_araddr == ipcr_off) o_rdata <= {24'h0, 1'b0, cos_q, 1'b0, ipst_q};
      else if (i_araddr == isr_off) o_rdata <= {24'h0, isr};
      else if (i_araddr == imr_off) o_rdata <= {24'h0, imr_q};
      else if (i_araddr == ctl_off) o_rdata <= {24'h0, ctl_q};
      else o_rdata <= 32'h0000_0000;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

endmodule

// File: duart_ctl_pkg.sv
package duart_ctl_pkg;
  // register byte offsets (one aligned word each)
  localparam logic [7:0] cmd_a_off = 8'h00;
  localparam logic [7:0] rxb_a_off = 8'h04;
  localparam logic [7:0] txb_a_off = 8'h08;
  localparam logic [7:0] sts_a_off = 8'h0c;
  localparam logic [7:0] cmd_b_off = 8'h10;
  localparam logic [7:0] rxb_b_off = 8'h14;
  localparam logic [7:0] txb_b_off = 8'h18;
  localparam logic [7:0] sts_b_off = 8'h1c;
  localparam logic [7:0] ipcr_off = 8'h20;
  localparam logic [7:0] acr_off = 8'h24;
  localparam logic [7:0] isr_off = 8'h28;
  localparam logic [7:0] imr_off = 8'h2c;
  localparam logic [7:0] ctl_off = 8'h30;
  localparam logic [7:0] acr_reset = 8'h00;
  // command register fields
  localparam int rx_cmd_lsb = 0;
  localparam int tx_cmd_lsb = 2;
  localparam int op_lsb = 4;
  // channel status bits
  localparam int st_rdy = 0;
  localparam int st_full = 1;
  localparam int st_tx_holding_free = 2;
  localparam int st_tx_idle_flag = 3;
  localparam int st_oe = 4;
  localparam int st_pe = 5;
  localparam int st_fe = 6;
  localparam int st_rb = 7;
  // interrupt status bits
  localparam int isr_txa = 0;
  localparam int isr_rxa = 1;
  localparam int isr_dba = 2;
  localparam int isr_txb = 4;
  localparam int isr_rxb = 5;
  localparam int isr_dbb = 6;
  localparam int isr_cos = 7;
  // control register bits
  localparam int ctl_loop = 0;
  localparam int ctl_mdrop = 1;
  typedef enum logic [2:0] {
    op_none = 3'b000, op_mptr = 3'b001, op_rst_rx = 3'b010, op_rst_tx = 3'b011,
    op_rst_err = 3'b100, op_rst_brk = 3'b101, op_brk_on = 3'b110, op_brk_off = 3'b111
  } chan_op_type;
  localparam logic [1:0] cmd_nop = 2'b00;
  localparam logic [1:0] cmd_en = 2'b01;
  localparam logic [1:0] cmd_dis = 2'b10;
  localparam int rxq_depth = 3;
  // timing: 20 MHz clock, 16 samples a bit
  localparam int clk_hz = 20000000;
  localparam int baud_hz = 9600;
  localparam int sample_div = clk_hz / (baud_hz * 16);
  localparam int cos_filter_us = 25;
  localparam int cos_filter_cyc = (cos_filter_us * (clk_hz / 1000000));
  typedef enum logic [1:0] {tx_idle = 2'b00, tx_shift = 2'b01, tx_brk = 2'b11} tx_state_type;
  typedef enum logic [1:0] {rx_off = 2'b00, rx_hunt = 2'b01, rx_data = 2'b11} rx_state_type;
endpackage

// File: duart_ctl_assertions.sv
`timescale 1ns/1ps
// ==========
// port checker
module duart_ctl_assertions
  import duart_ctl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic [2:0] i_general_input_pins,
  input wire logic [1:0] o_serial_out_pin,
  input wire logic o_irq,
  input wire logic o_mode_ptr_first
);
  logic bv_q, rv_q, wk_q, cl_q, hi_q;
  logic [7:0] wa_q, ra_q, wd_q, mask_q;
  logic [1:0] en_q;
  logic [2:0] pin_q, zc_q;
  logic [10:0] st_q;
  logic [12:0] sb_q;
  wire wr = o_bvalid && !bv_q && wk_q;
  wire cmd = wr && (wa_q == cmd_a_off || wa_q == cmd_b_off);
  wire rdi = o_rvalid && !rv_q && ra_q == ipcr_off;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {bv_q, rv_q, wk_q, cl_q, hi_q, wa_q, ra_q, wd_q, mask_q} <= '0;
      {en_q, pin_q, zc_q, st_q, sb_q} <= '0;
    end else begin
      bv_q <= o_bvalid;
      rv_q <= o_rvalid;
      pin_q <= i_general_input_pins;
      if (i_awvalid && o_awready) wa_q <= i_awaddr;
      if (i_arvalid && o_arready) ra_q <= i_araddr;
      if (i_wvalid && o_wready) begin
        wd_q <= i_wdata[7:0];
        wk_q <= i_wstrb[0];
      end
      if (wr && wa_q == imr_off) mask_q <= wd_q;
      if (cmd && wd_q[3:2] == cmd_en) en_q[wa_q == cmd_b_off] <= 1'b1;
      if (mask_q != 8'h00 || (i_awvalid && o_awready && i_awaddr == imr_off)) zc_q <= '0;
      else if (zc_q != 3'd7) zc_q <= zc_q + 3'd1;
      if (i_general_input_pins != pin_q) st_q <= '0;
      else if (st_q != 11'h7ff) st_q <= st_q + 11'd1;
      if (i_general_input_pins != pin_q) cl_q <= 1'b0;
      else if (rdi && st_q > 11'd600) cl_q <= 1'b1;
      if (cmd && wa_q == cmd_a_off && wd_q[6:4] == 3'b111) begin
        sb_q <= 13'd1;
        hi_q <= 1'b0;
      end else begin
        if (sb_q != 13'd0 && sb_q != 13'h1fff) sb_q <= sb_q + 13'd1;
        hi_q <= hi_q | o_serial_out_pin[0];
      end
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  chk_mode_ptr_set: assert property (cmd && wd_q[6:4] == 3'b001 |-> ##[0:1] o_mode_ptr_first)
    else $error("mode pointer flag not set");
  chk_mode_ptr_clear: assert property (cmd && wd_q[6:4] != 3'b001 |-> ##[0:1] !o_mode_ptr_first)
    else $error("mode pointer flag not cleared");
  chk_irq_reset_low: assert property ($rose(i_rst_b) |-> !o_irq)
    else $error("irq high after reset");
  chk_irq_needs_mask: assert property (o_irq |-> zc_q < 3'd4)
    else $error("irq with empty mask");
  chk_line_idle_off: assert property ((o_serial_out_pin | en_q) == 2'b11)
    else $error("serial line left mark before enable");
  chk_stop_mark: assert property (sb_q == 13'd4400 |-> hi_q)
    else $error("line not back to mark after stop");
  chk_pin_state: assert property (rdi && st_q > 11'd600 |-> o_rdata[2:0] == pin_q)
    else $error("input state bits wrong");
  chk_change_clear: assert property (rdi && cl_q |-> o_rdata[6:4] == 3'b000)
    else $error("change flags survived read");
  cover property (o_irq);
  cover property (rdi && o_rdata[6:4] != 3'b000);
  cover property (sb_q == 13'd4400);
endmodule
bind duart_ctl duart_ctl_assertions duart_ctl_assertions_inst (.i_clk, .i_rst_b, .i_awaddr, .i_awvalid,
  .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bvalid, .i_araddr, .i_arvalid, .o_arready,
  .o_rdata, .o_rvalid, .i_general_input_pins, .o_serial_out_pin, .o_irq, .o_mode_ptr_first);

// File: serial_term_model.sv
`timescale 1ns/1ps
// ==========
// remote terminal, 8 data bits, one stop bit
module serial_term_model #(
  parameter int bit_cyc = 2080
) (
  input wire logic i_clk,
  input wire logic [1:0] i_line,
  output logic [1:0] o_line
);
  initial o_line = 2'b11;
  task automatic send(input int ch, input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_line[ch] <= f[i];
      repeat (bit_cyc) @(posedge i_clk);
    end
  endtask
  task automatic recv(input int ch, output logic [7:0] d);
    while (i_line[ch] !== 1'b0) @(posedge i_clk);
    repeat (bit_cyc / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge i_clk);
      d[i] = i_line[ch];
    end
  endtask
endmodule

// File: test_dual_uart_channel_command_status.sv
`timescale 1ns/1ps
// ==========
// bench
module test_dual_uart_channel_command_status;
  import duart_ctl_pkg::*;
  logic i_clk, i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, o_mode_ptr_first;
  logic [7:0] i_awaddr, i_araddr, d;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp, i_serial_in_pin, o_serial_out_pin;
  logic [2:0] i_general_input_pins;
  int num_errors = 0;
  int samples_checked = 0;
  duart_ctl duart_ctl_inst (.i_clk, .i_rst_b, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
    .o_rresp, .o_rvalid, .i_rready, .i_serial_in_pin, .o_serial_out_pin, .i_general_input_pins, .o_irq,
    .o_mode_ptr_first);
  serial_term_model #(.bit_cyc(sample_div * 16)) serial_term_model_inst (.i_clk, .i_line(o_serial_out_pin),
    .o_line(i_serial_in_pin));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_awaddr <= a;
    i_wdata <= {24'h0, v};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    chk("write resp", 8'h00, 8'(o_bresp));
    i_bready <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    v = o_rdata[7:0];
    chk("read upper bits", 8'h00, o_rdata[15:8] | o_rdata[23:16] | o_rdata[31:24]);
    chk("read resp", 8'h00, 8'(o_rresp));
    i_rready <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic t_reset;
    rd(isr_off, d);
    chk("status after reset", 8'h00, d);
    rd(8'h3c, d);
    chk("unmapped read", 8'h00, d);
    $display("reset test done");
  endtask
  task automatic t_ops;
    for (int op = 0; op < 8; op++) begin
      wr(cmd_b_off, {1'b0, 3'(op), 4'h0});
      chk("mode pointer", 8'(op == 1), 8'(o_mode_ptr_first));
      chk("line b idle", 8'h01, 8'(o_serial_out_pin[1]));
    end
    $display("command decode test done");
  endtask
  task automatic t_tx;
    wr(cmd_a_off, 8'h04);
    rd(sts_a_off, d);
    chk("tx flags on enable", 8'h0c, d & 8'h0c);
    wr(txb_a_off, 8'h5a);
    serial_term_model_inst.recv(0, d);
    chk("sent char", 8'h5a, d);
    wr(cmd_a_off, 8'h30);
    rd(sts_a_off, d);
    chk("tx flags on reset", 8'h00, d & 8'h0c);
    $display("transmit test done");
  endtask
  task automatic t_break;
    wr(cmd_a_off, 8'h04);
    wr(cmd_a_off, 8'h60);
    repeat (2200) @(posedge i_clk);
    chk("break level", 8'h00, 8'(o_serial_out_pin[0]));
    wr(cmd_a_off, 8'h70);
    repeat (4300) @(posedge i_clk);
    chk("mark after stop", 8'h01, 8'(o_serial_out_pin[0]));
    $display("break test done");
  endtask
  task automatic t_rx;
    wr(cmd_b_off, 8'h01);
    serial_term_model_inst.send(1, 8'ha5);
    serial_term_model_inst.send(1, 8'h3c);
    rd(sts_b_off, d);
    chk("rx ready", 8'h01, d & 8'h03);
    rd(rxb_b_off, d);
    chk("rx char", 8'ha5, d);
    wr(cmd_b_off, 8'h20);
    rd(sts_b_off, d);
    chk("rx flags on reset", 8'h00, d & 8'h03);
    $display("receive test done");
  endtask
  task automatic t_cos;
    wr(acr_off, 8'h01);
    wr(imr_off, 8'h80);
    i_general_input_pins <= 3'b110;
    repeat (700) @(posedge i_clk);
    chk("irq on change", 8'h01, 8'(o_irq));
    rd(ipcr_off, d);
    chk("change reg", 8'h16, d);
    rd(isr_off, d);
    chk("status bit 7 cleared", 8'h00, d & 8'h80);
    rd(ipcr_off, d);
    chk("change flags cleared", 8'h06, d);
    chk("irq dropped", 8'h00, 8'(o_irq));
    i_general_input_pins <= 3'b100;
    repeat (700) @(posedge i_clk);
    rd(isr_off, d);
    chk("disabled pin change", 8'h00, d & 8'h80);
    $display("input change test done");
  endtask
  initial begin
    i_rst_b = 1'b0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    i_awaddr = 8'h00;
    i_araddr = 8'h00;
    i_wdata = 32'h0;
    i_wstrb = 4'hf;
    i_general_input_pins = 3'b111;
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    t_reset;
    t_ops;
    t_tx;
    t_break;
    t_rx;
    t_cos;
    end_sim;
  end
  initial begin
    repeat (90000) @(posedge i_clk);
    num_errors++;
    end_sim;
  end
endmodule
